// ### hdl/idbo_regs.vh
// Purpose: register map and timing constants of the input debounce block
// Assumes: 32-bit classic Wishbone, byte addresses, 100 MHz sys_clk
// Notes:   word registers, 16 bits used in select and value, 6 in status, upper bits read as zero
`ifndef IDBO_REGS_VH
`define IDBO_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define IDBO_OFS_STATUS    4'h0
`define IDBO_OFS_SELECT    4'h4
`define IDBO_OFS_VALUE     4'h8

// ****************************************
// fields and reset values
// ****************************************
`define IDBO_NUM_INPUTS    6
`define IDBO_REG_WIDTH     16
`define IDBO_RST_SELECT    16'h0000
`define IDBO_RST_VALUE     16'h0000
`define IDBO_RST_STATUS    6'h00

// ****************************************
// timing
// ****************************************
`define IDBO_CLK_HZ        100000000
`define IDBO_SAMPLE_US     1000
// 1 ms at 100 MHz, sized to the 17-bit tick counter
`define IDBO_SAMPLE_CYC    17'h186A0

`endif

// ### hdl/idbo_input_debounce_override.v
// Purpose: six-input override and two-sample debounce with Wishbone regs
// Assumes: classic Wishbone slave, 32-bit data, one sys_clk domain
// Notes:   ack is a one-cycle pulse one edge after the request is seen
//          sample period is a parameter so a bench may shorten it
//          bits 15:6 of select and value are kept but drive nothing
//
// Functional notes
// - filtered levels of inputs one to six in status bits zero to five
// - new level accepted after two equal consecutive samples, 1 to 2 ms after it appears
// - status word is read-only; writes to it change nothing
// - select bit one uses forced bit, zero uses the real pin level
// - select bits zero to five map to inputs one to six
// - select and forced-value registers clear to zero on reset
// - forced value of input one in bit zero, input six in bit five
// - forced bit ignored unless that input's select bit is set
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`include "idbo_regs.vh"

module idbo_input_debounce_override #(
  // sys_clk cycles per sample tick; the default gives 1 ms
  parameter [16:0] SAMPLE_CYC = `IDBO_SAMPLE_CYC
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        nrst,

  // input contacts
  input  wire        input_pin_1,
  input  wire        input_pin_2,
  input  wire        input_pin_3,
  input  wire        input_pin_4,
  input  wire        input_pin_5,
  input  wire        input_pin_6,

  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         wb_err_o,

  // filtered levels
  output reg  [5:0]  debounced_input_ff
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  wire [5:0] pins_raw;
  reg  [5:0] pin_meta_ff;
  reg  [5:0] pin_sync_ff;

  assign pins_raw = {input_pin_6, input_pin_5, input_pin_4,
                     input_pin_3, input_pin_2, input_pin_1};

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta_ff <= 6'h00;
    end else begin
      pin_meta_ff <= pins_raw;
    end
  end

  // only this stage reads the first flop, never the filter
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_sync_ff <= 6'h00;
    end else begin
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // ****************************************
  // bus decode
  // ****************************************
  wire        wb_req;
  wire        hit_status;
  wire        hit_select;
  wire        hit_value;
  wire        adr_ok;
  wire        rd_req;
  wire        wr_req;
  wire        lane_lo;
  wire        lane_hi;
  wire        sel_wr_lo;
  wire        sel_wr_hi;
  wire        val_wr_lo;
  wire        val_wr_hi;

  // one wait state: ack never stands in the cycle of the request
  assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign hit_status = (wb_adr_i == `IDBO_OFS_STATUS);
  assign hit_select = (wb_adr_i == `IDBO_OFS_SELECT);
  assign hit_value  = (wb_adr_i == `IDBO_OFS_VALUE);
  assign adr_ok     = hit_status | hit_select | hit_value;
  assign rd_req     = wb_req & ~wb_we_i & adr_ok;
  assign wr_req     = wb_req & wb_we_i & adr_ok;

  // only lanes 0 and 1 hold register bits; lanes 2 and 3 are ignored
  assign lane_lo    = wb_sel_i[0];
  assign lane_hi    = wb_sel_i[1];
  assign sel_wr_lo  = wr_req & hit_select & lane_lo;
  assign sel_wr_hi  = wr_req & hit_select & lane_hi;
  assign val_wr_lo  = wr_req & hit_value & lane_lo;
  assign val_wr_hi  = wr_req & hit_value & lane_hi;

  // ****************************************
  // override select register
  // ****************************************
  reg  [15:0] input_override_select_ff;
  reg  [15:0] nxt_select;

  always @* begin
    nxt_select = input_override_select_ff;
    if (sel_wr_lo) begin
      nxt_select[7:0] = wb_dat_i[7:0];
    end
    if (sel_wr_hi) begin
      nxt_select[15:8] = wb_dat_i[15:8];
    end
  end

  // boot and power cycle both arrive here as nrst
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      input_override_select_ff <= `IDBO_RST_SELECT;
    end else begin
      input_override_select_ff <= nxt_select;
    end
  end

  // ****************************************
  // override value register
  // ****************************************
  reg  [15:0] input_override_value_ff;
  reg  [15:0] nxt_value;

  always @* begin
    nxt_value = input_override_value_ff;
    if (val_wr_lo) begin
      nxt_value[7:0] = wb_dat_i[7:0];
    end
    if (val_wr_hi) begin
      nxt_value[15:8] = wb_dat_i[15:8];
    end
  end

  // forced bits are kept even while their select bit is clear
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      input_override_value_ff <= `IDBO_RST_VALUE;
    end else begin
      input_override_value_ff <= nxt_value;
    end
  end

  // ****************************************
  // status word
  // ****************************************
  // no store behind the status offset: a write is answered and dropped
  wire [31:0] status_word;

  assign status_word = {26'h0000000, debounced_input_ff};

  // ****************************************
  // read data and answer
  // ****************************************
  reg  [31:0] nxt_rdata;
  reg         nxt_ack;
  reg         nxt_err;

  always @* begin
    nxt_rdata = 32'h00000000;
    if (rd_req) begin
      case (wb_adr_i)
        `IDBO_OFS_STATUS: nxt_rdata = status_word;
        `IDBO_OFS_SELECT: nxt_rdata = {16'h0000, input_override_select_ff};
        `IDBO_OFS_VALUE:  nxt_rdata = {16'h0000, input_override_value_ff};
        default:          nxt_rdata = 32'h00000000;
      endcase
    end
  end

  // an unmapped offset gets err instead of ack, with no effect
  always @* begin
    nxt_ack = wb_req & adr_ok;
    nxt_err = wb_req & ~adr_ok;
  end

  // both answers are one-cycle pulses: wb_req is gated by them
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= nxt_ack;
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wb_err_o <= 1'b0;
    end else begin
      wb_err_o <= nxt_err;
    end
  end

  // read data stands with ack only and is zero otherwise
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_dat_o <= nxt_rdata;
    end
  end

  // ****************************************
  // sample tick
  // ****************************************
  reg  [16:0] tick_cnt_ff;
  reg  [16:0] nxt_tick_cnt;
  reg         tick_ff;
  wire        tick_wrap;

  // one-cycle enable pulse; the filter stays on sys_clk
  assign tick_wrap = (tick_cnt_ff == SAMPLE_CYC - 17'h00001);

  always @* begin
    if (tick_wrap) begin
      nxt_tick_cnt = 17'h00000;
    end else begin
      nxt_tick_cnt = tick_cnt_ff + 17'h00001;
    end
  end

  // restarts on reset, so the first tick is a full period late
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_ff <= 17'h00000;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= tick_wrap;
    end
  end

  // ****************************************
  // override and debounce per input
  // ****************************************
  reg  [5:0] last_sample_ff;
  wire [5:0] use_forced;
  wire [5:0] forced_level;
  wire [5:0] agree;

  genvar gi;
  generate
    for (gi = 0; gi < `IDBO_NUM_INPUTS; gi = gi + 1) begin : g_in
      // bit gi of select and value serves input gi+1
      assign use_forced[gi] = input_override_select_ff[gi];
      assign forced_level[gi] = use_forced[gi] ?
                                input_override_value_ff[gi] :
                                pin_sync_ff[gi];

      // a one-sample glitch never reaches the status word
      assign agree[gi] = (forced_level[gi] == last_sample_ff[gi]);

      // previous sample, refreshed on every tick
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          last_sample_ff[gi] <= 1'b0;
        end else if (tick_ff) begin
          last_sample_ff[gi] <= forced_level[gi];
        end
      end

      // symmetric filter: rising and falling changes wait alike
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          debounced_input_ff[gi] <= 1'b0;
        end else if (tick_ff & agree[gi]) begin
          debounced_input_ff[gi] <= forced_level[gi];
        end
      end
    end
  endgenerate

endmodule

// ### bench/idbo_props.sv
// Purpose: bus answer and filter checks
// Assumes: one clock domain
// Notes:   bound to the top module
`timescale 1ns/10ps
module idbo_props (
  input wire        sys_clk,
  input wire        nrst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [3:0]  wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        wb_err_o,
  input wire [5:0]  debounced_input_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire mp = wb_adr_i == 4'h0 || wb_adr_i == 4'h4 || wb_adr_i == 4'h8;
  a_req_answer: assert property (tk |=> wb_ack_o != wb_err_o)
    else $error("no single answer");
  a_err_unmap: assert property (tk && !mp |=> wb_err_o) else $error("no err");
  a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_err_drop: assert property (wb_err_o |=> !wb_err_o) else $error("err held");
  a_quiet_bus: assert property (!wb_cyc_i |=> !wb_ack_o && !wb_err_o)
    else $error("answer without request");
  a_status_read: assert property (tk && !wb_we_i && !wb_adr_i |=>
    wb_dat_o == {26'h0, $past(debounced_input_ff)}) else $error("status");
  a_read_upper: assert property (wb_ack_o |-> !wb_dat_o[31:16])
    else $error("upper bits set");
  a_deb_settle: assert property (!$stable(debounced_input_ff) |=>
    $stable(debounced_input_ff)[*8]) else $error("filter too fast");
  c_write: cover property (tk && wb_we_i);
  c_err: cover property (wb_err_o);
  c_change: cover property (!$stable(debounced_input_ff));
endmodule
bind idbo_input_debounce_override idbo_props u_props (.*);

// ### bench/idbo_contacts.sv
// Purpose: six input contacts; Assumes: bench sets levels; Notes: no bounce
`timescale 1ns/10ps
module idbo_contacts (
  input  wire [5:0] level,
  output wire [5:0] pins
);
  assign pins = level;
endmodule

// ### bench/idbo_input_debounce_override_tb.sv
// Purpose: bench; Assumes: 100-cycle tick; Notes: short filter waits
`timescale 1ns/10ps
module idbo_input_debounce_override_tb;
  reg         sys_clk, nrst, cyc, we, erq;
  reg  [3:0]  adr;
  reg  [31:0] dat, q;
  reg  [5:0]  lv;
  wire [31:0] rd;
  wire [5:0]  deb, p;
  wire        ack, err;
  integer     fail_count, checked, n;
  idbo_contacts u_pins (.level(lv), .pins(p));
  idbo_input_debounce_override #(.SAMPLE_CYC(17'h00064))
    dut (.sys_clk(sys_clk), .nrst(nrst),
    .input_pin_1(p[0]), .input_pin_2(p[1]), .input_pin_3(p[2]),
    .input_pin_4(p[3]), .input_pin_5(p[4]), .input_pin_6(p[5]),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
    .wb_err_o(err), .debounced_input_ff(deb));
  task summarize;
    begin
      $display("checked %0d failed %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // classic cycle: hold until ack or err is seen at a rising edge
  task wb(input w, input [3:0] a, input [15:0] d);
    begin
      @(posedge sys_clk);
      cyc <= 1'b1; we <= w; adr <= a; dat <= {16'h0000, d};
      n = 0;
      @(posedge sys_clk);
      while (ack !== 1'b1 && err !== 1'b1 && n < 20) begin
        @(posedge sys_clk);
        n = n + 1;
      end
      q = rd;
      erq = err;
      cyc <= 1'b0;
      if (n == 20) begin
        fail_count = fail_count + 1;
        summarize;
      end
    end
  endtask
  task rst;
    begin
      nrst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
    end
  endtask
  task t_regs;
    begin
      wb(0, 4'h4, 16'h0000); chk(q, 32'h0);
      wb(0, 4'h8, 16'h0000); chk(q, 32'h0);
      wb(0, 4'hC, 16'h0000); chk(erq, 1'b1);
      wb(1, 4'h8, 16'h0025);
      wb(1, 4'h4, 16'h003F);
      repeat (90) @(posedge sys_clk);
      chk(deb, 6'h00);
      repeat (210) @(posedge sys_clk);
      chk(deb, 6'h25);
      wb(1, 4'h0, 16'hFFFF);
      wb(0, 4'h0, 16'h0000);
      chk(q, 32'h00000025);
      wb(0, 4'h4, 16'h0000); chk(q, 32'h0000003F);
      $display("t_regs done");
    end
  endtask
  task t_mask;
    begin
      wb(1, 4'h8, 16'h0027);
      wb(1, 4'h4, 16'h0002);
      repeat (90) @(posedge sys_clk);
      chk(deb, 6'h25);
      repeat (210) @(posedge sys_clk);
      chk(deb, 6'h02);
      lv <= 6'h0B;
      rst;
      wb(0, 4'h4, 16'h0000); chk(q, 32'h0);
      wb(0, 4'h8, 16'h0000); chk(q, 32'h0);
      repeat (300) @(posedge sys_clk);
      chk(deb, 6'h0B);
      $display("t_mask done");
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    cyc = 1'b0; we = 1'b0; erq = 1'b0;
    adr = 4'h0; dat = 32'h0; lv = 6'h00; fail_count = 0; checked = 0;
    rst; t_regs; t_mask; summarize;
  end
endmodule
